// ===== rtl/disp_wr_map.svh
// Constants for the display bus write decoder: bit positions, patterns, reset values.
// Assumes the module bus is sampled on clk_i and all bus levels are negative true.
//
// Overview of operation
// - Accept writes only on matching module address
// - Function bit one selects cursor row command
// - Function bit zero selects cursor column command
// - Row command stores display-off from bit seven
// - Row command captures five-bit row from bits
// - Column command captures seven-bit column, ignores bit
// - Fetch-off bit sampled on row strobe
// - Bus lines are negative true
// - No poll response is ever driven
// - Display timing derives from one clock
// - No read path back to processor
// - Strobes latch values that form cursor
`ifndef DISP_WR_MAP_SVH
`define DISP_WR_MAP_SVH

`define ADDR_WIDTH 16
`define DATA_WIDTH 8
`define ADDR_FIXED_LOW_BIT 12
`define ADDR_MOD_BIT_A 11
`define ADDR_MOD_BIT_B 10
`define ADDR_MOD_BIT_C 9
`define ADDR_MOD_BIT_D 4
`define FUNCTION_SELECT_BIT 5
`define DISPLAY_OFF_BIT 7
`define FETCH_OFF_BIT 6
`define ROW_MSB 4
`define COLUMN_MSB 6
`define ROW_WIDTH 5
`define COLUMN_WIDTH 7
`define ROW_RESET 5'h00
`define COLUMN_RESET 7'h00
`define DISPLAY_OFF_RESET 1'b0
`define FETCH_OFF_RESET 1'b0
`define DOT_RATE_KHZ 21060

`endif

// ===== rtl/disp_wr_pkg.sv
// Types for the display bus write decoder.
// Assumes disp_wr_map.svh is available on the include path.
package disp_wr_pkg;
  `include "disp_wr_map.svh"

  typedef struct packed {
    logic [`ROW_WIDTH-1:0] row;
    logic [`COLUMN_WIDTH-1:0] column;
    logic display_off;
    logic fetch_off;
  } cursor_state_s;

  typedef struct packed {
    logic row_take;
    logic column_take;
    logic [`DATA_WIDTH-1:0] data;
  } write_cmd_s;
endpackage

// ===== rtl/display_bus_write_decoder.sv
// Write-only decoder for cursor row, cursor column, display-off and fetch-off controls.
// Assumes bus inputs are synchronous to clk_i, which is the dot-rate clock.
`include "disp_wr_map.svh"

module display_bus_write_decoder #(
  parameter int unsigned ADDR_W = `ADDR_WIDTH,
  parameter int unsigned DATA_W = `DATA_WIDTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] addr_n_i,
  input wire logic [DATA_W-1:0] data_n_i,
  input wire logic req_n_i,
  input wire logic write_n_i,
  input wire logic io_n_i,
  input wire logic [`ROW_WIDTH-1:0] raster_row_i,
  input wire logic [`COLUMN_WIDTH-1:0] raster_column_i,
  output logic cursor_row_strobe_o,
  output logic cursor_column_strobe_o,
  output disp_wr_pkg::cursor_state_s state_o,
  output logic cursor_here_o
);
  import disp_wr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Module address match on logical levels
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = !a[`ADDR_FIXED_LOW_BIT] && a[`ADDR_MOD_BIT_A] && a[`ADDR_MOD_BIT_B]
               && a[`ADDR_MOD_BIT_C] && a[`ADDR_MOD_BIT_D];
  endfunction

  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic cycle;
  logic hit;
  logic take;
  logic cycle_q;
  write_cmd_s cmd;

  assign addr = ~addr_n_i;
  assign data = ~data_n_i;
  assign cycle = !req_n_i && !write_n_i && !io_n_i;
  assign hit = addr_hit(addr);
  assign take = cycle && hit && !cycle_q;
  assign cmd.row_take = take && addr[`FUNCTION_SELECT_BIT];
  assign cmd.column_take = take && !addr[`FUNCTION_SELECT_BIT];
  assign cmd.data = data;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cycle_q <= 1'b0;
    end else begin
      cycle_q <= cycle;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Holding registers

  cursor_state_s state_q;
  cursor_state_s state_d;
  logic row_strobe_q;
  logic column_strobe_q;

  always_comb begin
    state_d = state_q;
    if (cmd.row_take) begin
      state_d.display_off = cmd.data[`DISPLAY_OFF_BIT];
      state_d.row = cmd.data[`ROW_MSB:0];
      state_d.fetch_off = cmd.data[`FETCH_OFF_BIT];
    end
    if (cmd.column_take) begin
      state_d.column = cmd.data[`COLUMN_MSB:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= '{row: `ROW_RESET, column: `COLUMN_RESET,
                   display_off: `DISPLAY_OFF_RESET, fetch_off: `FETCH_OFF_RESET};
      row_strobe_q <= 1'b0;
      column_strobe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      row_strobe_q <= cmd.row_take;
      column_strobe_q <= cmd.column_take;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cursor compare

  logic cursor_here_q;
  logic cursor_match;

  assign cursor_match = (raster_row_i == state_q.row) && (raster_column_i == state_q.column)
                        && !state_q.display_off;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cursor_here_q <= 1'b0;
    end else begin
      cursor_here_q <= cursor_match;
    end
  end

  assign cursor_row_strobe_o = row_strobe_q;
  assign cursor_column_strobe_o = column_strobe_q;
  assign state_o = state_q;
  assign cursor_here_o = cursor_here_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_row_write;
    cmd.row_take ##1 row_strobe_q;
  endsequence

  sequence s_column_write;
    cmd.column_take ##1 column_strobe_q;
  endsequence

  a_strobe_from_hit: assert property (
    (row_strobe_q || column_strobe_q) |-> $past(cycle && hit))
    else $error("strobe without matching address");

  a_row_on_select: assert property (
    row_strobe_q |-> $past(addr[`FUNCTION_SELECT_BIT]))
    else $error("row strobe with function bit low");

  a_column_on_select: assert property (
    column_strobe_q |-> !$past(addr[`FUNCTION_SELECT_BIT]))
    else $error("column strobe with function bit high");

  a_display_off_capture: assert property (
    s_row_write |-> state_q.display_off == $past(data[`DISPLAY_OFF_BIT]))
    else $error("display-off not captured");

  a_row_capture: assert property (
    cmd.row_take |=> row_strobe_q && state_q.row == $past(data[`ROW_MSB:0]))
    else $error("row not captured");

  a_column_capture: assert property (
    s_column_write |-> state_q.column == $past(data[`COLUMN_MSB:0]))
    else $error("column not captured");

  a_fetch_off_capture: assert property (
    cmd.row_take |=> state_q.fetch_off == $past(data[`FETCH_OFF_BIT]))
    else $error("fetch-off not captured");

  a_negative_true: assert property (
    (cycle && hit && !cycle_q && !addr_n_i[`FUNCTION_SELECT_BIT]) |=> row_strobe_q)
    else $error("low bus level not read as one");

  a_cursor_follows: assert property (
    cursor_match |=> cursor_here_o)
    else $error("cursor compare not registered");

  a_values_hold: assert property (
    !cmd.row_take && !cmd.column_take |=> $stable(state_q))
    else $error("state changed without write");

  a_single_strobe: assert property (
    (row_strobe_q || column_strobe_q) |=> !row_strobe_q && !column_strobe_q)
    else $error("strobe longer than one cycle");

  a_strobe_exclusive: assert property (
    !(row_strobe_q && column_strobe_q))
    else $error("both strobes at once");

  a_refused_address: assert property (
    (cycle && !hit) |=> !row_strobe_q && !column_strobe_q)
    else $error("strobe for foreign address");

  a_memory_ignored: assert property (
    (!req_n_i && io_n_i) |=> !row_strobe_q && !column_strobe_q)
    else $error("strobe on memory cycle");

  a_read_ignored: assert property (
    (!req_n_i && write_n_i) |=> !row_strobe_q && !column_strobe_q)
    else $error("strobe on read cycle");

  a_take_strobes: assert property (
    (cmd.row_take || cmd.column_take) |=> (row_strobe_q || column_strobe_q))
    else $error("decoded write gave no strobe");

  a_row_keeps_column: assert property (
    s_row_write |-> $stable(state_q.column))
    else $error("row write changed column");

  a_column_keeps_row: assert property (
    s_column_write |-> $stable({state_q.row, state_q.display_off, state_q.fetch_off}))
    else $error("column write changed row or controls");

  a_cursor_blank: assert property (
    !cursor_match |=> !cursor_here_o)
    else $error("cursor shown off position");

  a_display_off_blanks: assert property (
    state_q.display_off |=> !cursor_here_o)
    else $error("cursor shown while display off");

endmodule // display_bus_write_decoder

// ===== verification/proc_bus_model.sv
// Processor model that drives byte-wide read or write, memory or I/O cycles to the decoder over the module bus.
// Assumes pull-ups hold every released bus line high, i.e. logical zero.
module proc_bus_model (
  input wire logic clk_i,
  output logic [15:0] addr_n_o,
  output logic [7:0] data_n_o,
  output logic req_n_o,
  output logic write_n_o,
  output logic io_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {addr_n_o, data_n_o, req_n_o, write_n_o, io_n_o} = '1;
  end
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic w, input logic io);
    @(posedge clk_i);
    #2;
    addr_n_o = ~a;
    data_n_o = ~d;
    req_n_o = 1'h0;
    write_n_o = ~w;
    io_n_o = ~io;
    @(posedge clk_i);
    #2;
    {addr_n_o, data_n_o, req_n_o, write_n_o, io_n_o} = '1;
  endtask
endmodule // proc_bus_model

// ===== verification/testbench.sv
// Self-checking bench for the display bus write decoder.
// Assumes proc_bus_model drives the bus and the design keeps its default widths.
module testbench;
  import disp_wr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0;
  logic rst_n_i;
  logic [15:0] addr_n;
  logic [7:0] data_n;
  logic req_n, write_n, io_n, row_stb, col_stb, here;
  logic [4:0] raster_row;
  logic [6:0] raster_col;
  cursor_state_s st, m;
  logic [15:0] exp_q[$];
  logic [15:0] a;
  int seed, i, n_mismatch, total_checks;
  always #25 clk_i = ~clk_i;
  proc_bus_model proc (.clk_i(clk_i), .addr_n_o(addr_n), .data_n_o(data_n), .req_n_o(req_n),
    .write_n_o(write_n), .io_n_o(io_n));
  display_bus_write_decoder dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_n_i(addr_n),
    .data_n_i(data_n), .req_n_i(req_n), .write_n_i(write_n), .io_n_i(io_n),
    .raster_row_i(raster_row), .raster_column_i(raster_col), .cursor_row_strobe_o(row_stb),
    .cursor_column_strobe_o(col_stb), .state_o(st), .cursor_here_o(here));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic w, input logic io);
    if (w && io && !a[12] && a[11:9] == 3'h7 && a[4]) begin
      if (a[5]) begin
        m.row = d[4:0];
        m.display_off = d[7];
        m.fetch_off = d[6];
      end else begin
        m.column = d[6:0];
      end
      exp_q.push_back({a[5], !a[5], m});
    end
    proc.cycle(a, d, w, io);
  endtask
  always @(posedge clk_i) begin
    #1;
    if (row_stb !== 1'h0 || col_stb !== 1'h0) begin
      if (exp_q.size() == 0) check(16'(exp_q.size()), 16'h0001);
      else check({row_stb, col_stb, st}, exp_q.pop_front());
    end
  end
  initial begin
    seed = 32'h41f0;
    rst_n_i = 1'h0;
    raster_row = 5'h00;
    raster_col = 7'h00;
    m = '0;
    repeat (4) @(posedge clk_i);
    #2;
    rst_n_i = 1'h1;
    #10;
    check({row_stb, col_stb, st}, 16'h0000);
    check({15'h0, here}, 16'h0000);
    $display("test reset done");
    for (i = 0; i < 40; i++) begin
      a = 16'($random(seed));
      a[12] = 1'h0;
      a[11:9] = 3'h7;
      a[4] = 1'h1;
      wr(a, 8'($random(seed)), 1'h1, 1'h1);
    end
    $display("test random writes done");
    for (i = 0; i < 7; i++) begin
      a = 16'h0E10;
      a[5] = i[0];
      case (i)
        0: a[12] = 1'h1;
        1: a[11] = 1'h0;
        2: a[10] = 1'h0;
        3: a[9] = 1'h0;
        4: a[4] = 1'h0;
        default: ;
      endcase
      wr(a, 8'($random(seed)), i != 5, i != 6);
    end
    check({2'h0, st}, {2'h0, m});
    $display("test refusals done");
    for (i = 0; i < 2; i++) begin
      wr(16'h0E30, {i[0], 7'h0A}, 1'h1, 1'h1);
      raster_row = m.row;
      raster_col = m.column;
      repeat (2) @(posedge clk_i);
      #1;
      check({15'h0, here}, {15'h0, !m.display_off});
      #1;
      raster_col = m.column ^ 7'h01;
      repeat (2) @(posedge clk_i);
      #1;
      check({15'h0, here}, 16'h0000);
    end
    check(16'(exp_q.size()), 16'h0000);
    $display("test cursor compare done");
    final_report();
  end
endmodule // testbench
